// ===== verilog/mcp_card.sv
`timescale 1ns/1ps
`include "mcp_map.svh"
// Overview of operation
// [RQ1] erase sets addressed byte to ff
// [RQ2] write only clears bits to zero
// [RQ3] raising a bit needs erase then write
// [RQ4] equal data skips erase and write
// [RQ5] each cycle lasts 2.5 ms, busy covers
// [RQ6] no programming before a read or reset answer
// [RQ7] main update programs addressed main byte
// [RQ8] protected main byte is never updated
// [RQ9] lock only when data matches byte
// [RQ10] lock above address 1f ignored
// [RQ11] secret update programs addressed security byte
// [RQ12] secret update above address 03 ignored
// [RQ13] reset pin aborts, releases io, ready
// [RQ14] reset answer: 32 bits lsb first
// [RQ15] extra clock after answer releases io
// [RQ16] io released from power-up
// [RQ17] reset answer bytes are main 0..3
// [RQ18] locked low bytes stay unalterable
// [RQ19] only 24-bit frames execute
// [RQ20] io low while busy, high after
// [RQ21] opcodes 38, 39, 3c decoded
// [RQ22] frame bytes arrive lsb first
// [RQ23] main bytes above 31 unprotected
// [RQ24] programming needs write-enable flag
// [RQ25] prior-read flag gates every cycle
// [RQ26] no rising bit means write only

// ****************************************
// frame buffer
// ****************************************
module mcp_fifo #(
   parameter int W = `MCP_FIFO_WIDTH,
   parameter int D = `MCP_FIFO_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } mcp_fifo_rec_t;
   mcp_fifo_rec_t f_q, f_d;
   logic push, pop;

   // handshakes
   assign in_ready = f_q.cnt != (AW+1)'(D);
   assign out_valid = f_q.cnt != '0;
   assign out_data = f_q.mem[f_q.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // pointer and count update
   always_comb begin
      f_d = f_q;
      if (push) begin
         f_d.mem[f_q.wp] = in_data;
         f_d.wp = f_q.wp + 1'b1;
      end
      if (pop) begin
         f_d.rp = f_q.rp + 1'b1;
      end
      f_d.cnt = f_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (flush) begin
         f_d.wp = '0;
         f_d.rp = '0;
         f_d.cnt = '0;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end
endmodule : mcp_fifo

// ****************************************
// card controller
// ****************************************
module mcp_card import mcp_pkg::*; #(
   parameter int unsigned PROG_CYCLES = `MCP_PROG_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // terminal pins
   input wire logic card_clk,
   input wire logic card_rst,
   input wire logic io_in,
   output logic io_out,
   output logic io_oe,
   // verification result
   input wire logic wr_enable
);
   mcp_rec_t s_q, s_d;
   logic rise, fall, io_rise, io_fall;
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;
   logic [`MCP_FIFO_WIDTH-1:0] fifo_out_data;
   logic [7:0] w_ctrl, w_addr, w_data, cur;
   logic is_prog, ok, low;
   logic [5:0] b;

   // filtered level: change once second and third stages agree
   function automatic logic filt(input logic [2:0] s, input logic f);
      filt = (s[1] == s[2]) ? s[2] : f;
   endfunction : filt

   mcp_fifo #(.W(`MCP_FIFO_WIDTH), .D(`MCP_FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .flush(fifo_flush),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data({~(s_q.bits == `MCP_STOP_RISES), s_q.frame}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // open drain: only ever pulls low
   assign io_out = 1'b0;
   assign io_oe = s_q.oe;

   // frame word fields
   assign w_ctrl = fifo_out_data[`MCP_F_CTRL];
   assign w_addr = fifo_out_data[`MCP_F_ADDR];
   assign w_data = fifo_out_data[`MCP_F_DATA];
   assign low = w_addr <= `MCP_PROT_MAX;

   // next state
   always_comb begin
      s_d = s_q;
      fifo_in_valid = 1'b0;
      fifo_out_ready = 1'b0;
      fifo_flush = 1'b0;
      is_prog = 1'b0;
      ok = 1'b0;
      cur = s_q.mem[w_addr];
      b = 6'h0;
      s_d.clk_s = {s_q.clk_s[1:0], card_clk};
      s_d.io_s = {s_q.io_s[1:0], io_in};
      s_d.rst_s = {s_q.rst_s[1:0], card_rst};
      s_d.clk_f = filt(s_q.clk_s, s_q.clk_f);
      s_d.io_f = filt(s_q.io_s, s_q.io_f);
      s_d.rst_f = filt(s_q.rst_s, s_q.rst_f);
      rise = s_d.clk_f & ~s_q.clk_f;
      fall = ~s_d.clk_f & s_q.clk_f;
      io_rise = s_d.io_f & ~s_q.io_f;
      io_fall = ~s_d.io_f & s_q.io_f;
      if (s_d.rst_f) begin
         // abort, drop pending frames, release io
         s_d.state = ST_RST; // RQ13
         s_d.oe = 1'b0; // RQ13
         fifo_flush = 1'b1;
      end else begin
         unique case (s_q.state)
            ST_IDLE: begin
               // start: io falls while clock high
               if (io_fall && s_q.clk_f) begin
                  s_d.state = ST_RX;
                  s_d.bits = 5'h0;
               end
            end
            ST_RX: begin
               if (rise && s_q.bits != 5'h1f) begin
                  s_d.bits = s_q.bits + 5'h1;
               end
               if (rise && s_q.bits < `MCP_FRAME_BITS) begin
                  s_d.frame = {s_d.io_f, s_q.frame[23:1]}; // RQ22
               end
               // stop: io rises while clock high
               if (io_rise && s_q.clk_f) begin
                  s_d.state = ST_PUSH;
               end
            end
            ST_PUSH: begin
               fifo_in_valid = 1'b1;
               if (fifo_in_ready) begin
                  s_d.state = ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (fifo_out_valid) begin
                  fifo_out_ready = 1'b1;
                  s_d.addr = w_addr;
                  s_d.data = w_data;
                  s_d.cnt = 16'h0;
                  s_d.falls = 4'h0;
                  // prior read and write enable gate every programming command
                  ok = ~fifo_out_data[`MCP_F_BAD] & s_q.prior_read & wr_enable; // RQ6 RQ25 RQ24 RQ19
                  unique case (w_ctrl)
                     `MCP_OP_UPD_MAIN: begin
                        is_prog = 1'b1;
                        s_d.tgt = TGT_MAIN; // RQ7
                        ok = ok & ~(low & s_q.prot[w_addr[4:0]]); // RQ8 RQ18 RQ23
                     end
                     `MCP_OP_UPD_SEC: begin
                        is_prog = 1'b1;
                        s_d.tgt = TGT_SEC; // RQ11
                        cur = s_q.sec[w_addr[1:0]];
                        ok = ok & (w_addr <= `MCP_SEC_MAX); // RQ12
                     end
                     `MCP_OP_WR_PROT: begin
                        is_prog = 1'b1;
                        s_d.tgt = TGT_PROT;
                        ok = ok & low & (w_data == s_q.mem[w_addr]); // RQ9 RQ10
                        ok = ok & ~s_q.prot[w_addr[4:0]];
                     end
                     default: begin
                        is_prog = 1'b0; // RQ21
                     end
                  endcase
                  if (is_prog && s_d.tgt != TGT_PROT) begin
                     ok = ok & (w_data != cur); // RQ4
                  end
                  if (!fifo_out_data[`MCP_F_BAD] &&
                      (w_ctrl == `MCP_OP_RD_MAIN || w_ctrl == `MCP_OP_RD_SEC || w_ctrl == `MCP_OP_RD_PROT)) begin
                     s_d.prior_read = 1'b1;
                     s_d.state = ST_IDLE;
                  end else begin
                     s_d.oe = 1'b1; // RQ20
                     if (is_prog && ok) begin
                        // erase only when some bit must rise
                        if (s_d.tgt != TGT_PROT && (w_data & ~cur) != 8'h0) begin
                           s_d.state = ST_ERASE; // RQ3
                        end else begin
                           s_d.state = ST_WRITE; // RQ26
                        end
                     end else begin
                        s_d.state = ST_FAULT;
                     end
                  end
               end
            end
            ST_ERASE: begin
               s_d.cnt = s_q.cnt + 16'h1;
               if (s_q.cnt == 16'(PROG_CYCLES - 1)) begin // RQ5
                  s_d.cnt = 16'h0;
                  s_d.state = ST_WRITE; // RQ3
                  if (s_q.tgt == TGT_MAIN) begin
                     s_d.mem[s_q.addr] = `MCP_ERASED; // RQ1
                  end else begin
                     s_d.sec[s_q.addr[1:0]] = `MCP_ERASED; // RQ1
                  end
               end
            end
            ST_WRITE: begin
               s_d.cnt = s_q.cnt + 16'h1;
               if (s_q.cnt == 16'(PROG_CYCLES - 1)) begin // RQ5
                  s_d.state = ST_DONE;
                  unique case (s_q.tgt)
                     TGT_MAIN: s_d.mem[s_q.addr] = s_q.mem[s_q.addr] & s_q.data; // RQ2
                     TGT_SEC: s_d.sec[s_q.addr[1:0]] = s_q.sec[s_q.addr[1:0]] & s_q.data; // RQ2
                     TGT_PROT: s_d.prot[s_q.addr[4:0]] = 1'b1; // RQ9 RQ18
                  endcase
               end
            end
            ST_FAULT: begin
               // refused or faulty: release after eight falls
               if (fall) begin
                  s_d.falls = s_q.falls + 4'h1;
                  if (s_d.falls == `MCP_FAULT_FALLS) begin
                     s_d.state = ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               s_d.oe = 1'b0; // RQ20
               s_d.state = ST_IDLE;
            end
            ST_RST: begin
               // reset pin released: answer begins
               s_d.state = ST_ATR;
               s_d.idx = 6'h0;
               s_d.prior_read = 1'b1; // RQ6
            end
            ST_ATR: begin
               if (fall) begin
                  s_d.idx = s_q.idx + 6'h1;
               end
               b = s_d.idx - 6'h1;
               if (s_d.idx != 6'h0 && s_d.idx <= `MCP_ATR_BITS) begin
                  s_d.oe = ~s_q.mem[b[4:3]][b[2:0]]; // RQ14 RQ17
               end else begin
                  s_d.oe = 1'b0;
               end
               if (s_d.idx == `MCP_ATR_END) begin
                  s_d.state = ST_IDLE; // RQ15
               end
            end
         endcase
      end
   end

   // state register; stores come up erased and unlocked
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_q <= '0; // RQ16
         // io filter starts at the pulled-up level, so no false edge
         s_q.io_s <= {3{`MCP_IO_IDLE}};
         s_q.io_f <= `MCP_IO_IDLE;
         s_q.mem <= {256{`MCP_ERASED}};
         s_q.sec <= {4{`MCP_ERASED}};
         s_q.prot <= `MCP_PROT_RESET;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : mcp_card

// ===== verilog/mcp_map.svh
`ifndef MCP_MAP_SVH
`define MCP_MAP_SVH
// ****************************************
// opcodes of the control byte
// ****************************************
`define MCP_OP_UPD_MAIN 8'h38
`define MCP_OP_UPD_SEC 8'h39
`define MCP_OP_WR_PROT 8'h3c
`define MCP_OP_RD_MAIN 8'h30
`define MCP_OP_RD_SEC 8'h31
`define MCP_OP_RD_PROT 8'h34
// ****************************************
// store limits and reset values
// ****************************************
`define MCP_ERASED 8'hff
`define MCP_PROT_MAX 8'h1f
`define MCP_SEC_MAX 8'h03
`define MCP_PROT_RESET 32'h0000_0000
`define MCP_IO_IDLE 1'b1
// ****************************************
// frame word field positions
// ****************************************
`define MCP_F_CTRL 7:0
`define MCP_F_ADDR 15:8
`define MCP_F_DATA 23:16
`define MCP_F_BAD 24
`define MCP_FIFO_WIDTH 25
`define MCP_FIFO_DEPTH 16
// ****************************************
// counts and timing
// ****************************************
`define MCP_FRAME_BITS 5'd24
`define MCP_STOP_RISES 5'd25
`define MCP_ATR_BITS 6'd32
`define MCP_ATR_END 6'd33
`define MCP_FAULT_FALLS 4'd8
`define MCP_SYS_CLK_NS 100
`define MCP_PROG_TIME_NS 2500000
`define MCP_PROG_CYCLES ((`MCP_PROG_TIME_NS + `MCP_SYS_CLK_NS - 1) / `MCP_SYS_CLK_NS)
`endif

// ===== verilog/mcp_pkg.sv
package mcp_pkg;
   // ****************************************
   // controller states and store targets
   // ****************************************
   typedef enum {ST_IDLE, ST_RX, ST_PUSH, ST_EXEC, ST_ERASE, ST_WRITE, ST_FAULT, ST_DONE, ST_RST, ST_ATR} mcp_state_t;
   typedef enum logic [1:0] {TGT_MAIN, TGT_SEC, TGT_PROT} mcp_tgt_t;

   // all state of the card controller
   typedef struct packed {
      logic [2:0] clk_s;
      logic [2:0] io_s;
      logic [2:0] rst_s;
      logic clk_f;
      logic io_f;
      logic rst_f;
      mcp_state_t state;
      logic [23:0] frame;
      logic [4:0] bits;
      logic [5:0] idx;
      logic [3:0] falls;
      logic [15:0] cnt;
      mcp_tgt_t tgt;
      logic [7:0] addr;
      logic [7:0] data;
      logic prior_read;
      logic oe;
      logic [255:0][7:0] mem;
      logic [31:0] prot;
      logic [3:0][7:0] sec;
   } mcp_rec_t;
endpackage : mcp_pkg

// ===== testbench/mcp_card_asserts.sv
`timescale 1ns/1ps
module mcp_card_asserts #(
   parameter int unsigned PROG_CYCLES = 20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // terminal pins
   input wire logic card_clk,
   input wire logic card_rst,
   input wire logic io_in,
   input wire logic io_out,
   input wire logic io_oe,
   // verification result
   input wire logic wr_enable
);
   // ****
   // helper state
   // ****
   logic clk_q;
   logic io_q;
   logic fall;
   logic [3:0] age;
   logic [3:0] falls;
   logic [5:0] atr_n;
   logic [15:0] run;
   assign fall = clk_q & ~card_clk;
   // event age, busy run length, falls in run, answer window
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         clk_q <= 1'b0;
         io_q <= 1'b1;
         age <= 4'hf;
         falls <= 4'h0;
         atr_n <= 6'h00;
         run <= 16'h0000;
      end else begin
         clk_q <= card_clk;
         io_q <= io_in;
         age <= (fall | (~io_q & io_in & card_clk)) ? 4'h0 : age + {3'h0, age != 4'hf};
         falls <= ~io_oe ? 4'h0 : falls + {3'h0, fall & (falls != 4'hf)};
         atr_n <= card_rst ? 6'h21 : atr_n - {5'h00, fall & (atr_n != 6'h00)};
         run <= io_oe ? run + 16'h0001 : 16'h0000;
      end
   end
   // ****
   // properties
   // ****
   AST_IO_OUT_ZERO: assert property (@(posedge sys_clk) disable iff (reset) io_out == 1'b0)
      else $error("io output not zero");
   AST_POR_RELEASED: assert property (@(posedge sys_clk) disable iff (reset) $fell(reset) |-> !io_oe [*4])
      else $error("io pulled after power-up");
   AST_RST_ABORT: assert property (@(posedge sys_clk) disable iff (reset) card_rst [*6] |-> !io_oe)
      else $error("io pulled during reset pin");
   AST_RST_QUIET: assert property (@(posedge sys_clk) disable iff (reset) $fell(card_rst) |-> !io_oe [*3])
      else $error("io pulled before first answer clock");
   AST_OE_CAUSE: assert property (@(posedge sys_clk) disable iff (reset) $rose(io_oe) |-> age <= 4'hc)
      else $error("io pulled without stop or clock fall");
   AST_BUSY_HOLDS: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(io_oe) && !card_rst |=> io_oe [*6])
      else $error("busy level too short");
   AST_RUN_BOUND: assert property (@(posedge sys_clk) disable iff (reset)
      io_oe |-> run <= 2 * PROG_CYCLES + 1 || falls <= 4'h8)
      else $error("busy run too long");
   AST_RUN_EXACT: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(io_oe) && falls < 4'h8 && atr_n == 6'h00 && $past(atr_n, 8) == 6'h00
      |-> run == PROG_CYCLES + 1 || run == 2 * PROG_CYCLES + 1)
      else $error("program busy length wrong");
endmodule : mcp_card_asserts

// ===== testbench/mcp_terminal.sv
`timescale 1ns/1ps
module mcp_terminal (
   // timing grid
   input wire logic sys_clk,
   // terminal pins
   output logic card_clk,
   output logic card_rst,
   output logic io_drv,
   input wire logic io_in
);
   // pins idle: clock low, io released
   initial begin
      card_clk = 1'b0;
      card_rst = 1'b0;
      io_drv = 1'b1;
   end
   // wait n system clocks, then step off the edge
   task automatic hold(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : hold
   // one 800 ns clock pulse
   task automatic pulse();
      card_clk = 1'b1;
      hold(4);
      card_clk = 1'b0;
      hold(4);
   endtask : pulse
   // reset pin high 6 us, clock low
   task automatic reset_pin();
      card_rst = 1'b1;
      hold(60);
      card_rst = 1'b0;
      hold(8);
   endtask : reset_pin
   // start, n bits lsb first, extra pulse, stop
   task automatic send(input logic [23:0] w, input int n);
      card_clk = 1'b1;
      hold(4);
      io_drv = 1'b0;
      hold(4);
      card_clk = 1'b0;
      hold(2);
      for (int i = 0; i < n; i++) begin
         io_drv = w[i];
         hold(2);
         card_clk = 1'b1;
         hold(4);
         card_clk = 1'b0;
         hold(2);
      end
      io_drv = 1'b0;
      hold(2);
      card_clk = 1'b1;
      hold(2);
      io_drv = 1'b1;
      hold(2);
      card_clk = 1'b0;
      hold(10);
   endtask : send
   // keep clocking while the card holds io low
   task automatic finish();
      for (int k = 0; k < 400 && io_in === 1'b0; k++) begin
         pulse();
      end
   endtask : finish
   // 32 answer bits, then the releasing pulse
   task automatic read_atr(output logic [31:0] v);
      for (int k = 0; k < 32; k++) begin
         card_clk = 1'b1;
         hold(4);
         card_clk = 1'b0;
         hold(8);
         v[k] = io_in;
      end
      pulse();
      hold(8);
   endtask : read_atr
endmodule : mcp_terminal

// ===== testbench/mcp_card_tb_top.sv
`timescale 1ns/1ps
`include "mcp_map.svh"
module mcp_card_tb_top import mcp_pkg::*;;
   localparam int unsigned PROG = 20;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic wr_enable = 1'b1;
   logic card_clk;
   logic card_rst;
   logic io_drv;
   logic io_out;
   logic io_oe;
   wire io_w;
   int fail_count = 0;
   int checks = 0;
   int run_n = 0;
   int last_run = 0;
   // open-drain wire with pull-up
   assign io_w = io_drv & ~io_oe;
   // system clock
   always #50 sys_clk = ~sys_clk;
   mcp_card #(.PROG_CYCLES(PROG)) mcp_card_i (.sys_clk(sys_clk), .reset(reset), .card_clk(card_clk),
      .card_rst(card_rst), .io_in(io_w), .io_out(io_out), .io_oe(io_oe), .wr_enable(wr_enable));
   mcp_terminal mcp_terminal_i (.sys_clk(sys_clk), .card_clk(card_clk), .card_rst(card_rst),
      .io_drv(io_drv), .io_in(io_w));
   // length of the last busy run
   always @(posedge sys_clk) begin
      if (io_oe === 1'b1) begin
         run_n++;
      end else if (run_n != 0) begin
         last_run = run_n;
         run_n = 0;
      end
   end
   // ****
   // shared tasks
   // ****
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // 1 write only, 2 erase and write, 3 refused
   function automatic logic [31:0] kind(input int n);
      if (n == PROG + 1) return 32'h1;
      if (n == 2 * PROG + 1) return 32'h2;
      return (n > 2 * PROG + 5) ? 32'h3 : 32'h0;
   endfunction : kind
   task automatic prog(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d, input int n,
      input logic [31:0] exp);
      last_run = 0;
      mcp_terminal_i.send({d, a, op}, n);
      mcp_terminal_i.finish();
      cmp("busy kind", exp, kind(last_run));
   endtask : prog
   task automatic reset_answer(input logic [31:0] exp);
      logic [31:0] v;
      mcp_terminal_i.reset_pin();
      cmp("io before answer", 32'h1, {31'h0, io_w});
      mcp_terminal_i.read_atr(v);
      cmp("reset answer", exp, v);
      cmp("io after answer", 32'h1, {31'h0, io_w});
   endtask : reset_answer
   // ****
   // scenarios
   // ****
   task automatic t_no_prior();
      prog(`MCP_OP_UPD_MAIN, 8'h00, 8'h00, 24, 32'h3);
      reset_answer(32'hffff_ffff);
   endtask : t_no_prior
   task automatic t_erase_write();
      prog(`MCP_OP_UPD_MAIN, 8'h00, 8'h5a, 24, 32'h1);
      prog(`MCP_OP_UPD_MAIN, 8'h00, 8'ha5, 24, 32'h2);
      prog(`MCP_OP_UPD_MAIN, 8'h00, 8'ha5, 24, 32'h3);
      prog(`MCP_OP_UPD_MAIN, 8'h01, 8'h0f, 24, 32'h1);
      reset_answer(32'hffff_0fa5);
   endtask : t_erase_write
   task automatic t_lock();
      prog(`MCP_OP_WR_PROT, 8'h00, 8'h00, 24, 32'h3);
      prog(`MCP_OP_WR_PROT, 8'h20, 8'hff, 24, 32'h3);
      prog(`MCP_OP_WR_PROT, 8'h00, 8'ha5, 24, 32'h1);
      prog(`MCP_OP_UPD_MAIN, 8'h00, 8'hff, 24, 32'h3);
      prog(`MCP_OP_UPD_MAIN, 8'h40, 8'h33, 24, 32'h1);
   endtask : t_lock
   task automatic t_sec();
      prog(`MCP_OP_UPD_SEC, 8'h03, 8'h81, 24, 32'h1);
      prog(`MCP_OP_UPD_SEC, 8'h04, 8'h00, 24, 32'h3);
   endtask : t_sec
   task automatic t_gate();
      wr_enable = 1'b0;
      prog(`MCP_OP_UPD_MAIN, 8'h01, 8'h00, 24, 32'h3);
      wr_enable = 1'b1;
      prog(`MCP_OP_UPD_MAIN, 8'h01, 8'h00, 23, 32'h3);
      reset_answer(32'hffff_0fa5);
   endtask : t_gate
   task automatic t_abort();
      mcp_terminal_i.send({8'h00, 8'h02, `MCP_OP_UPD_MAIN}, 24);
      mcp_terminal_i.hold(4);
      mcp_terminal_i.reset_pin();
      cmp("io after abort", 32'h0, {31'h0, io_oe});
      reset_answer(32'hffff_0fa5);
   endtask : t_abort
   // second power-up: prior-read flag cleared, a read command sets it again
   task automatic t_power_cycle();
      reset = 1'b1;
      repeat (12) @(posedge sys_clk);
      #2;
      reset = 1'b0;
      repeat (6) @(posedge sys_clk);
      #2;
      cmp("io after second power-up", 32'h0, {31'h0, io_oe});
      cmp("io output level", 32'h0, {31'h0, io_out});
      prog(`MCP_OP_UPD_MAIN, 8'h41, 8'h00, 24, 32'h3);
      mcp_terminal_i.send({8'h00, 8'h00, `MCP_OP_RD_MAIN}, 24);
      cmp("io after read", 32'h0, {31'h0, io_oe});
      prog(`MCP_OP_UPD_MAIN, 8'h41, 8'h00, 24, 32'h1);
   endtask : t_power_cycle
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      #2;
      reset = 1'b0;
      repeat (6) @(posedge sys_clk);
      #2;
      cmp("io after power-up", 32'h0, {31'h0, io_oe});
      t_no_prior();
      t_erase_write();
      t_lock();
      t_sec();
      t_gate();
      t_abort();
      t_power_cycle();
      test_done();
   end
   // watchdog
   initial begin
      #3000000;
      fail_count++;
      $display("FAIL watchdog expected end seen hang");
      test_done();
   end
endmodule : mcp_card_tb_top
bind mcp_card mcp_card_asserts #(.PROG_CYCLES(PROG_CYCLES)) mcp_card_asserts_i (.sys_clk(sys_clk),
   .reset(reset), .card_clk(card_clk), .card_rst(card_rst), .io_in(io_in), .io_out(io_out),
   .io_oe(io_oe), .wr_enable(wr_enable));
